/* core/cmcl_top.sv */
// Purpose: Per-mailbox configuration, remote reply, overrun and retry control
// Assumes: Receive and transmit engines sit outside and speak by pulses
// Notes: Registers on a plain address/strobe port, read data one cycle later
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "cmcl_consts.svh"
// Register map, one 32-bit word per address on the plain port:
//   0x00-0x0f  control word of mailbox n at address n
//              [2:0] configuration, 111 leaves the mailbox idle
//              [3]   auto reply to remote frames
//              [4]   no retry after a failed attempt
//              [5]   overwrite mode: 1 lets a new message replace unread data
//              [6]   acceptance mask in use (read only)
//   0x10       remote pending, one bit per mailbox, write 1 to clear
//   0x11       unread, one bit per mailbox, write 1 to clear
//   0x12       overwrite mode of all mailboxes (read only mirror)
//   0x13       transmit pending, write 1 to set
//   0x14       transmit cancel, write 1 to set
// Any other address reads as zero and ignores writes.
//
// Timing on the register port:
//   a write takes effect at the edge that samples the strobe;
//   read data stand for the single cycle after the read strobe;
//   the mask output follows a configuration write one cycle later.
//
// Transmit handshake with the protocol engine:
//   the engine raises TX_GRANT while the bus is free;
//   one cycle after a grant meets an eligible mailbox, TX_START pulses
//   with TX_MB and TX_AS_DATA standing beside it;
//   the engine then ends the attempt with one pulse of TX_DONE or TX_FAIL.
// Only one attempt is in flight, so the engine never sees overlapping starts.
//
// Receive handshake:
//   RX_VALID pulses once per message, with RX_MB and RX_REMOTE beside it;
//   RX_STORE pulses one cycle later when the payload must be written;
//   no pulse follows for a dropped overrun or an auto-replied remote frame.
// Limitation: a prohibited configuration code is stored as written and
// treated as active; software must not use those codes.
//
// Flag precedence: a hardware set in the same cycle as a software clear
// wins, so no event is lost to a badly timed write.
// Clearing remote pending while unread is still set, with auto reply on,
// re-arms the flag and queues the reply; this is how an overrun remote
// frame gets its answer.
// Turning auto reply off leaves a pending flag and a queued reply alone.
//
// Transmit choice: the lowest numbered mailbox that is pending, not
// cancelled and active wins; there is no priority by identifier here,
// which the engine must add if it wants it.
// With no retry set, the cancel bit is raised at the start of the attempt,
// so a failure clears the pending bit instead of trying again.
// A cancel written by software during an attempt acts the same way.
//
// Mailbox zero has configuration bit 1 forced high, keeping it a receiver.
// Reset leaves every mailbox idle, with all flags and outputs at zero.
module cmcl_top
    import cmcl_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic [`CMCL_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic RX_VALID,
    input wire logic [`CMCL_MB_IDX_W-1:0] RX_MB,
    input wire logic RX_REMOTE,
    output logic RX_STORE,
    output logic [`CMCL_MB_IDX_W-1:0] RX_STORE_MB,
    input wire logic TX_GRANT,
    input wire logic TX_DONE,
    input wire logic TX_FAIL,
    output logic TX_START,
    output logic [`CMCL_MB_IDX_W-1:0] TX_MB,
    output logic TX_AS_DATA,
    output logic [`CMCL_NUM_MB-1:0] MASK_ACTIVE
);
    cmcl_state_s st_reg;
    cmcl_state_s st_next;

    // Find the lowest numbered mailbox eligible for transmission
    function automatic logic [`CMCL_MB_IDX_W:0] pick(input cmcl_vec_t req);
        logic [`CMCL_MB_IDX_W:0] r;
        r = '0;
        for (int i = `CMCL_NUM_MB - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                r = {1'b1, i[`CMCL_MB_IDX_W-1:0]};
            end
        end
        return r;
    endfunction : pick

    cmcl_vec_t active;
    cmcl_vec_t elig;
    logic [`CMCL_MB_IDX_W:0] sel;
    logic sel_ok;
    logic [`CMCL_MB_IDX_W-1:0] sel_idx;
    logic ctrl_hit;
    logic wr_ctrl;
    logic wr_rpend;
    logic wr_unread;
    logic wr_txpend;
    logic wr_txcan;
    logic rd_ctrl;
    logic rx_hit;
    logic rx_overrun;
    logic rx_autoreply;

    // Address decode; the control words fill the bottom sixteen addresses
    always_comb
    begin
        ctrl_hit = ADDR[`CMCL_ADDR_W-1:`CMCL_MB_IDX_W] == '0;
        wr_ctrl = WR && ctrl_hit;
        wr_rpend = WR && ADDR == `CMCL_RPEND_OFS;
        wr_unread = WR && ADDR == `CMCL_UNREAD_OFS;
        wr_txpend = WR && ADDR == `CMCL_TXPEND_OFS;
        wr_txcan = WR && ADDR == `CMCL_TXCAN_OFS;
        // Reads decode on their own strobe, so back to back strobes are fine
        rd_ctrl = RD && ctrl_hit;
    end

    // Receive classification: dropped overrun, auto reply, or plain store
    always_comb
    begin
        rx_hit = RX_VALID && active[RX_MB];
        rx_overrun = st_reg.unread[RX_MB] && !st_reg.ovwmode[RX_MB];
        rx_autoreply = RX_REMOTE && st_reg.auto_reply_enable[RX_MB];
    end

    // Split the pick result into its valid bit and its index
    assign sel_ok = sel[`CMCL_MB_IDX_W];
    assign sel_idx = sel[`CMCL_MB_IDX_W-1:0];

    // Activity and transmit eligibility per mailbox
    always_comb
    begin
        for (int i = 0; i < `CMCL_NUM_MB; i++)
        begin
            active[i] = st_reg.cfg[i] != `CMCL_CFG_INACTIVE;
        end
        // Pending and not cancelled; inactive mailboxes never send
        elig = st_reg.txpend & ~st_reg.txcan & active;
        sel = pick(elig);
    end

    // Next-state logic for every register of the block
    always_comb
    begin
        logic [`CMCL_MB_IDX_W-1:0] w_idx;
        logic [`CMCL_MB_IDX_W-1:0] r_idx;
        cmcl_cfg_t wcfg;
        w_idx = ADDR[`CMCL_MB_IDX_W-1:0];
        r_idx = RX_MB;
        wcfg = WDATA[`CMCL_F_CFG_HI:`CMCL_F_CFG_LO];
        st_next = st_reg;
        st_next.txstart = 1'b0;
        st_next.rxstore = 1'b0;

        // Software writes: control word, plus flag writes
        if (wr_ctrl)
        begin
            // Separate copy of each mailbox's settings
            st_next.cfg[w_idx] = wcfg;
            st_next.auto_reply_enable[w_idx] = WDATA[`CMCL_F_ATX];
            st_next.noretry[w_idx] = WDATA[`CMCL_F_NORETRY];
            st_next.ovwmode[w_idx] = WDATA[`CMCL_F_OVWMODE];
        end
        if (wr_rpend)
        begin
            // Write one clears; an overrun pending flag re-arms the reply
            for (int i = 0; i < `CMCL_NUM_MB; i++)
            begin
                if (WDATA[i] && st_reg.rpend[i])
                begin
                    st_next.rpend[i] = 1'b0;
                    if (st_reg.unread[i] && st_reg.auto_reply_enable[i] && active[i])
                    begin
                        st_next.rpend[i] = 1'b1;
                        st_next.txpend[i] = 1'b1;
                    end
                end
            end
        end
        if (wr_unread)
        begin
            st_next.unread = st_reg.unread & ~WDATA[`CMCL_NUM_MB-1:0];
        end
        if (wr_txpend)
        begin
            // No guard against a receive mailbox; an active one is then picked and sent
            st_next.txpend = st_reg.txpend | WDATA[`CMCL_NUM_MB-1:0];
        end
        if (wr_txcan)
        begin
            st_next.txcan = st_reg.txcan | WDATA[`CMCL_NUM_MB-1:0];
        end
        // Mailbox zero can never be configured as a transmitter
        st_next.cfg[0][1] = 1'b1;

        // Reception: hardware sets win over software clears
        if (rx_hit)
        begin
            if (rx_overrun)
            begin
                // Overrun: keep old data, drop the new message
                st_next.unread[r_idx] = 1'b1;
                st_next.rpend[r_idx] = st_next.rpend[r_idx]
                    | rx_autoreply;
            end
            else if (rx_autoreply)
            begin
                // Notify by pending flag, reply with stored data
                st_next.rpend[r_idx] = 1'b1;
                st_next.txpend[r_idx] = 1'b1;
            end
            else
            begin
                st_next.rxstore = 1'b1;
                st_next.rxmb = r_idx;
                st_next.unread[r_idx] = 1'b1;
            end
        end

        // Transmit sequencing
        unique case (st_reg.txst)
            CMCL_IDLE:
            begin
                if (sel_ok && TX_GRANT)
                begin
                    st_next.txst = CMCL_BUSY;
                    st_next.txstart = 1'b1;
                    st_next.txmb = sel_idx;
                    // A pending remote flag means this attempt is the reply
                    st_next.txdata = st_reg.rpend[sel_idx];
                    if (st_reg.noretry[sel_idx])
                    begin
                        st_next.txcan[sel_idx] = 1'b1;
                    end
                end
            end
            CMCL_BUSY:
            begin
                if (TX_DONE)
                begin
                    st_next.txst = CMCL_IDLE;
                    st_next.txpend[st_reg.txmb] = 1'b0;
                    st_next.txcan[st_reg.txmb] = 1'b0;
                end
                else if (TX_FAIL)
                begin
                    // Pending stays set so it retries unless cancelled
                    st_next.txst = CMCL_IDLE;
                    if (st_reg.txcan[st_reg.txmb])
                    begin
                        st_next.txpend[st_reg.txmb] = 1'b0;
                        st_next.txcan[st_reg.txmb] = 1'b0;
                    end
                end
            end
            default:
            begin
                st_next.txst = CMCL_IDLE;
            end
        endcase

        // Acceptance mask follows any active configuration
        st_next.maskon = active;

        // Read path, data valid the cycle after the strobe
        st_next.rdata = '0;
        if (RD)
        begin
            if (rd_ctrl)
            begin
                st_next.rdata[`CMCL_F_CFG_HI:`CMCL_F_CFG_LO] = st_reg.cfg[w_idx];
                st_next.rdata[`CMCL_F_ATX] = st_reg.auto_reply_enable[w_idx];
                st_next.rdata[`CMCL_F_NORETRY] = st_reg.noretry[w_idx];
                st_next.rdata[`CMCL_F_OVWMODE] = st_reg.ovwmode[w_idx];
                st_next.rdata[`CMCL_F_MASKEN] = active[w_idx];
            end
            else
            begin
                unique case (ADDR)
                    `CMCL_RPEND_OFS: st_next.rdata[`CMCL_NUM_MB-1:0] = st_reg.rpend;
                    `CMCL_UNREAD_OFS: st_next.rdata[`CMCL_NUM_MB-1:0] = st_reg.unread;
                    `CMCL_OVW_OFS: st_next.rdata[`CMCL_NUM_MB-1:0] = st_reg.ovwmode;
                    `CMCL_TXPEND_OFS: st_next.rdata[`CMCL_NUM_MB-1:0] = st_reg.txpend;
                    `CMCL_TXCAN_OFS: st_next.rdata[`CMCL_NUM_MB-1:0] = st_reg.txcan;
                    default: st_next.rdata = '0;
                endcase
            end
        end
    end

    // State register; all mailboxes start inactive
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st_reg <= '0;
            st_reg.cfg <= {`CMCL_NUM_MB{`CMCL_CFG_RESET}};
            st_reg.txst <= CMCL_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign RDATA = st_reg.rdata;
    assign RX_STORE = st_reg.rxstore;
    assign RX_STORE_MB = st_reg.rxmb;
    assign TX_START = st_reg.txstart;
    assign TX_MB = st_reg.txmb;
    assign TX_AS_DATA = st_reg.txdata;
    assign MASK_ACTIVE = st_reg.maskon;
endmodule : cmcl_top

/* core/cmcl_consts.svh */
// Purpose: Constants for the CAN mailbox configuration logic
// Assumes: Included by the package and the top module
// Notes: Offsets are word addresses on the plain register port
`ifndef CMCL_CONSTS_SVH
`define CMCL_CONSTS_SVH
`define CMCL_NUM_MB 16
`define CMCL_MB_IDX_W 4
`define CMCL_ADDR_W 8
// Per mailbox control word at base + index
`define CMCL_CTRL_BASE 8'h00
// Global flag and status words; only the overwrite mirror is read only
`define CMCL_RPEND_OFS 8'h10
`define CMCL_UNREAD_OFS 8'h11
`define CMCL_OVW_OFS 8'h12
`define CMCL_TXPEND_OFS 8'h13
`define CMCL_TXCAN_OFS 8'h14
// Control word field positions
`define CMCL_F_CFG_LO 0
`define CMCL_F_CFG_HI 2
`define CMCL_F_ATX 3
`define CMCL_F_NORETRY 4
`define CMCL_F_OVWMODE 5
`define CMCL_F_MASKEN 6
// Configuration codes
`define CMCL_CFG_INACTIVE 3'h7
`define CMCL_CFG_RESET 3'h7
`define CMCL_CFG_RX_BIT 1
`endif

/* core/cmcl_pkg.sv */
// Purpose: Types for the CAN mailbox configuration logic
// Assumes: Constants come from cmcl_consts.svh
// Notes: State record of the top module
`include "cmcl_consts.svh"
package cmcl_pkg;
    typedef logic [`CMCL_NUM_MB-1:0] cmcl_vec_t;
    typedef logic [2:0] cmcl_cfg_t;
    typedef enum logic [1:0]
    {
        CMCL_IDLE = 2'b01,
        CMCL_BUSY = 2'b10
    } cmcl_tx_e;
    typedef struct packed
    {
        cmcl_cfg_t [`CMCL_NUM_MB-1:0] cfg;
        cmcl_vec_t auto_reply_enable;
        cmcl_vec_t noretry;
        cmcl_vec_t ovwmode;
        cmcl_vec_t rpend;
        cmcl_vec_t unread;
        cmcl_vec_t txpend;
        cmcl_vec_t txcan;
        cmcl_vec_t maskon;
        cmcl_tx_e txst;
        logic [`CMCL_MB_IDX_W-1:0] txmb;
        logic txstart;
        logic txdata;
        logic rxstore;
        logic [`CMCL_MB_IDX_W-1:0] rxmb;
        logic [31:0] rdata;
    } cmcl_state_s;
endpackage : cmcl_pkg

/* sim/cmcl_asserts.sv */
// Purpose: Port checks for cmcl_top
// Assumes: Config settles before traffic
// Notes: Mask lags writes by one cycle
`timescale 1ns/10ps
module cmcl_asserts
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic RX_VALID,
    input wire logic [3:0] RX_MB,
    input wire logic RX_STORE,
    input wire logic [3:0] RX_STORE_MB,
    input wire logic TX_GRANT,
    input wire logic TX_START,
    input wire logic [3:0] TX_MB,
    input wire logic [15:0] MASK_ACTIVE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!ARST_N);
    // Read data and stores only follow their cause
    AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("stray read data");
    AST_STORE_CAUSE: assert property (!$past(RX_VALID) |-> !RX_STORE)
        else $error("stray store");
    AST_STORE_MB: assert property (RX_STORE |-> RX_STORE_MB == $past(RX_MB))
        else $error("store to wrong box");
    // Inactive boxes stay out of traffic
    AST_RX_INACTIVE: assert property (RX_VALID && !MASK_ACTIVE[RX_MB] |=> !RX_STORE)
        else $error("inactive box stored");
    AST_TX_INACTIVE: assert property (TX_START |-> MASK_ACTIVE[TX_MB])
        else $error("inactive box sent");
    // Attempts need a free bus and never overlap
    AST_START_GRANT: assert property (TX_START |-> $past(TX_GRANT))
        else $error("start without grant");
    AST_START_GAP: assert property (TX_START |=> !TX_START [*2])
        else $error("starts too close");
    // Two cycles of quiet cover the mask lag
    AST_MASK_WR: assert property (!$past(WR) && !$past(WR, 2) |-> $stable(MASK_ACTIVE))
        else $error("mask moved without write");
    COV_STORE: cover property (RX_STORE);
    COV_DROP: cover property (RX_VALID && !MASK_ACTIVE[RX_MB]);
    COV_RETRY: cover property (TX_START ##[2:40] TX_START);
endmodule : cmcl_asserts
bind cmcl_top cmcl_asserts cmcl_asserts_inst (.REF_CLK, .ARST_N, .WR, .RD, .RDATA, .RX_VALID,
    .RX_MB, .RX_STORE, .RX_STORE_MB, .TX_GRANT, .TX_START, .TX_MB, .MASK_ACTIVE);

/* sim/cmcl_bus_nodes.sv */
// Purpose: Other CAN nodes seen through the transmit handshake
// Assumes: One frame in flight, a fixed number of cycles long
// Notes: lose ends each attempt in error, leaving retry to the controller
`timescale 1ns/10ps
module cmcl_bus_nodes
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic en,
    input wire logic lose,
    output logic grant,
    output logic done,
    output logic fail
);
    localparam int LAT = 8;
    logic [7:0] cnt_reg;
    logic lose_reg;
    // The outcome is fixed as the frame starts, so a later change of lose
    // cannot turn a failing attempt into a good one halfway through
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            lose_reg <= 1'b0;
        else if (start)
            lose_reg <= lose;
    // Count the frame out; the bus stays taken meanwhile
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            cnt_reg <= 8'h0;
        else if (start)
            cnt_reg <= 8'(LAT);
        else if (cnt_reg != 8'h0)
            cnt_reg <= cnt_reg - 8'h1;
    // One-cycle end pulses; grant only on an idle bus
    assign done = cnt_reg == 8'h1 && !lose_reg;
    assign fail = cnt_reg == 8'h1 && lose_reg;
    assign grant = en && cnt_reg == 8'h0;
endmodule : cmcl_bus_nodes

/* sim/testbench.sv */
// Purpose: Self-checking bench for cmcl_top
// Assumes: Config bit1 set means receive
// Notes: Scenario tasks judge their own results
`timescale 1ns/10ps
module testbench;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, rx_valid = 1'b0, rx_rem = 1'b0, en = 1'b0, lose = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] rx_mb = 4'h0, st_mb, tx_mb;
    logic [15:0] mask;
    logic store, start, as_data, grant, done, fail;
    int errors = 0, compares = 0;
    // 8 ns clock
    always #4 ref_clk = ~ref_clk;
    cmcl_top cmcl_top_inst (.REF_CLK(ref_clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .RX_VALID(rx_valid), .RX_MB(rx_mb), .RX_REMOTE(rx_rem),
        .RX_STORE(store), .RX_STORE_MB(st_mb), .TX_GRANT(grant), .TX_DONE(done), .TX_FAIL(fail),
        .TX_START(start), .TX_MB(tx_mb), .TX_AS_DATA(as_data), .MASK_ACTIVE(mask));
    cmcl_bus_nodes cmcl_bus_nodes_inst (.clk(ref_clk), .arst_n(arst_n), .start(start), .en(en),
        .lose(lose), .grant(grant), .done(done), .fail(fail));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bus cycles keep one idle cycle so no strobe is driven twice in a step
    task automatic put(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask : put
    task automatic get(logic [7:0] a, logic [31:0] exp, string what);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        chk(what, exp, rdata);
        @(posedge ref_clk);
    endtask : get
    task automatic rx(logic [3:0] mb, logic rem, logic exp, string what);
        rx_mb <= mb;
        rx_rem <= rem;
        rx_valid <= 1'b1;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        @(negedge ref_clk);
        chk(what, 32'({exp, mb}), 32'({store, store ? st_mb : mb}));
        @(posedge ref_clk);
    endtask : rx
    // Bounded wait for a start; a missing expected start ends the run
    task automatic txw(logic [3:0] mb, logic dat, logic exp, string what);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++)
        begin
            @(negedge ref_clk);
            seen = start;
        end
        chk(what, 32'({exp, dat, mb & {4{exp}}}), 32'({seen, as_data & seen, tx_mb & {4{seen}}}));
        if (exp && !seen)
            conclude();
        @(posedge ref_clk);
    endtask : txw
    // Permitted codes only; receive boxes never get tx pending
    task automatic t_regs();
        chk("mask rst", 32'h0, 32'(mask));
        get(8'h01, 32'h7, "ctrl rst");
        get(8'h15, 32'h0, "unmapped");
        put(8'h00, 32'h0);
        get(8'h00, 32'h42, "mb0 cfg");
        for (int i = 0; i < 4; i++)
        begin
            put(8'h01, 32'(i * 9));
            get(8'h01, 32'(i * 9) | 32'h40, "ctrl");
            chk("mask", 32'h3, 32'(mask));
        end
        put(8'h01, 32'h7);
        get(8'h01, 32'h7, "ctrl off");
        $display("regs done");
    endtask : t_regs
    task automatic t_rx();
        rx(4'h2, 1'b0, 1'b0, "inactive rx");
        put(8'h13, 32'h4);
        en <= 1'b1;
        txw(4'h2, 1'b0, 1'b0, "inactive tx");
        en <= 1'b0;
        put(8'h03, 32'h2);
        rx(4'h3, 1'b0, 1'b1, "store");
        rx(4'h3, 1'b0, 1'b0, "overrun");
        get(8'h11, 32'h8, "unread");
        put(8'h03, 32'h22);
        rx(4'h3, 1'b0, 1'b1, "overwrite");
        $display("rx done");
    endtask : t_rx
    task automatic t_remote();
        put(8'h04, 32'h8);
        rx(4'h4, 1'b1, 1'b0, "remote held");
        get(8'h10, 32'h10, "rpend");
        en <= 1'b1;
        txw(4'h4, 1'b1, 1'b1, "reply");
        txw(4'h4, 1'b0, 1'b0, "reply once");
        en <= 1'b0;
        put(8'h05, 32'h0);
        rx(4'h5, 1'b1, 1'b1, "no auto");
        rx(4'h4, 1'b0, 1'b1, "data in");
        rx(4'h4, 1'b1, 1'b0, "remote overrun");
        put(8'h10, 32'h10);
        get(8'h10, 32'h10, "rpend again");
        en <= 1'b1;
        txw(4'h4, 1'b1, 1'b1, "late reply");
        txw(4'h4, 1'b0, 1'b0, "late once");
        $display("remote done");
    endtask : t_remote
    task automatic t_retry();
        put(8'h06, 32'h0);
        lose <= 1'b1;
        put(8'h13, 32'h40);
        txw(4'h6, 1'b0, 1'b1, "try");
        lose <= 1'b0;
        txw(4'h6, 1'b0, 1'b1, "retry");
        txw(4'h6, 1'b0, 1'b0, "sent");
        put(8'h07, 32'h10);
        lose <= 1'b1;
        put(8'h13, 32'h80);
        txw(4'h7, 1'b0, 1'b1, "one try");
        get(8'h14, 32'h80, "cancel");
        txw(4'h7, 1'b0, 1'b0, "no retry");
        get(8'h13, 32'h4, "pend");
        $display("retry done");
    endtask : t_retry
    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_rx();
        t_remote();
        t_retry();
        conclude();
    end
endmodule : testbench
